//--- inc/itwhc_consts.vh
/*
 constants of the interrupt, tick, watchdog and halt control block.
 assumes inclusion by bare name from design files; definitions only.
*/
// Behaviour
// RULE_01 - irq control: global en b0, counter en b1, tick en b2, flags b4,b5; rest zero
// RULE_02 - pending enabled tick flag calls vector 08H, clears flag and global enable
// RULE_03 - no further acknowledge until irq return or enables set again, stack not full
// RULE_04 - irq return sets global enable; plain return leaves it alone
// RULE_05 - requests sampled and serviced at the next phase-two pulse
// RULE_06 - counter first at 04H, tick second at 08H; global enable masks both
// RULE_07 - watchdog on system clock, option removes it; then all its operations ignored
// RULE_08 - watchdog keeps counting in halt while oscillator runs; timeout wakes
// RULE_09 - overflow in normal run gives chip reset plus timeout flag; in halt warm reset
// RULE_10 - watchdog cleared by reset pin, halt, or clear instruction (last two stages)
// RULE_11 - watchdog timeout between 2^15 and 2^16 system clocks
// RULE_12 - shared 8-stage divider and 7-bit prescaler feed watchdog, tick and one-eighth clock
// RULE_13 - tick rate field selects period 2^(8+field); each timeout sets tick flag
// RULE_14 - tick keeps running in halt while oscillator runs; timeout wakes
// RULE_15 - halt stops phase one, clears watchdog, sets powerdown, clears timeout, standby option
// RULE_16 - port wake resumes next instruction; irq wake services if enabled and stack free
// RULE_17 - wake into acknowledge delayed over one cycle; wake into next instruction immediate
// RULE_18 - reset cause coded in timeout and powerdown flags
// RULE_19 - chip reset: pc zero, irqs off, dividers cleared, timer off, stack top
// RULE_20 - resets except watchdog wake load irq control zero, rate 111; watchdog wake keeps
// RULE_21 - flag already set at halt entry disables wake from that source
// RULE_22 - oscillator 32k or 128k by fixed option; system clock always 32k
// RULE_23 - pending enabled counter flag calls vector 04H, clears flag and global enable
// RULE_24 - no acknowledge while two-entry stack is full
// RULE_25 - software writes never change timeout or powerdown flags
// RULE_26 - a flag losing arbitration stays set and is served later
`ifndef ITWHC_CONSTS_VH
`define ITWHC_CONSTS_VH
`define ITWHC_IDX_TICK 8'h09
`define ITWHC_IDX_STAT 8'h0A
`define ITWHC_IDX_IRQ 8'h0B
`define ITWHC_OFS_TICK (`ITWHC_IDX_TICK << 2)
`define ITWHC_OFS_STAT (`ITWHC_IDX_STAT << 2)
`define ITWHC_OFS_IRQ (`ITWHC_IDX_IRQ << 2)
`define ITWHC_OFS_CMD 8'h30
`define ITWHC_OFS_CPU 8'h34
`define ITWHC_OFS_WAKE 8'h38
`define ITWHC_B_GIE 0
`define ITWHC_B_CIE 1
`define ITWHC_B_TIE 2
`define ITWHC_B_CF 4
`define ITWHC_B_TF 5
`define ITWHC_B_PDF 4
`define ITWHC_B_TOF 5
`define ITWHC_IRQ_RST 8'h00
`define ITWHC_RATE_RST 3'h7
`define ITWHC_VEC_CNT 12'h004
`define ITWHC_VEC_TICK 12'h008
`define ITWHC_VEC_RST 12'h000
`define ITWHC_CMD_CLRWDT 0
`define ITWHC_CMD_HALT 1
`define ITWHC_CMD_IRQ_RETURN_INSTR 2
`define ITWHC_CMD_RET 3
`define ITWHC_CMD_CALL 4
`define ITWHC_CMD_PWRUP 5
`define ITWHC_WDT_STAGES 17
`define ITWHC_WAKE_DLY 2'h2
`endif

//--- core/itwhc_divider.v
/*
 multi-function timer: 8-stage divider plus 7-bit prescaler and watchdog stages.
 assumes a level run enable, held high while counting, from the system clock domain.
*/
`timescale 1ns/10ps
`include "itwhc_consts.vh"
module itwhc_divider (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // control
  input wire run,
  input wire clear_all,
  input wire clear_wdt,
  input wire wdt_on,
  input wire [2:0] rate,
  // events
  output reg tick_evt,
  output reg wdt_evt,
  output wire fs8
);
  reg [14:0] pre_q;
  reg [1:0] wdt_q;
  wire [14:0] pre_inc;
  wire [3:0] rate_idx;
  assign pre_inc = pre_q + 15'h0001;
  assign fs8 = pre_q[2]; // RULE_12
  assign rate_idx = {1'b0, rate} + 4'h7;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre_q <= 15'h0000;
      wdt_q <= 2'h0;
      tick_evt <= 1'b0;
      wdt_evt <= 1'b0;
    end
    else if (clear_all)
    begin
      pre_q <= 15'h0000; // RULE_19
      wdt_q <= 2'h0;
      tick_evt <= 1'b0;
      wdt_evt <= 1'b0;
    end
    else
    begin
      tick_evt <= 1'b0;
      wdt_evt <= 1'b0;
      if (run)
      begin
        pre_q <= pre_inc; // RULE_12
        // tick when bit (7+rate) falls: period 2^(8+rate)
        tick_evt <= pre_q[rate_idx] & ~pre_inc[rate_idx]; // RULE_13
      end
      if (clear_wdt)
        wdt_q <= 2'h0; // RULE_10
      else if (run && wdt_on && pre_q == 15'h7FFF)
      begin
        // two last stages after the 2^15 chain; partial prefix not cleared gives 2^15..2^16
        wdt_q <= wdt_q + 2'h1; // RULE_11
        wdt_evt <= wdt_q[0]; // RULE_11
      end
    end
  end
endmodule

//--- core/itwhc_top.v
/*
 interrupt controller, tick, watchdog, halt and reset-cause logic with an ahb-lite register slave.
 assumes one 32-bit master, single word transfers; cpu events are one-cycle pulses.
*/
`timescale 1ns/10ps
`include "itwhc_consts.vh"
module itwhc_top (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire hready,
  // fixed options and pins
  input wire wdt_option_on,
  input wire osc_128k_option,
  input wire standby_option,
  input wire ext_reset_pin_n,
  input wire clock_phase_two,
  input wire port_wake,
  input wire counter_overflow,
  // cpu control outputs
  output reg clock_phase_one_en,
  output reg chip_reset,
  output reg warm_reset,
  output reg call_req,
  output reg [11:0] call_vector,
  output reg resume_next,
  output reg halted,
  output reg lcd_clk,
  output reg osc_run
);
  localparam ST_RUN = 3'b001;
  localparam ST_HALT = 3'b010;
  localparam ST_WAKE = 3'b100;

  reg [2:0] state_q;
  reg gie_q, cie_q, tie_q, cf_q, tf_q;
  reg [2:0] rate_q;
  reg tof_q, pdf_q;
  reg [1:0] sp_q;
  reg cf_mask_q, tf_mask_q;
  reg [1:0] wake_cnt_q;
  reg pin_q;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg [5:0] cmd_q;
  wire wdt_evt, tick_evt, fs8;
  wire run_div, stack_full, clr_wdt, wdt_overflow;
  wire acc_ok, set_cf, set_tf, pin_fall;
  wire c_req, t_req;

  function [7:0] irq_word;
    input g, ce, te, cf, tf;
    begin
      irq_word = {2'b00, tf, cf, 1'b0, te, ce, g}; // RULE_01
    end
  endfunction

  assign acc_ok = hsel & hready & htrans[1];
  assign stack_full = (sp_q == 2'h2);
  assign pin_fall = pin_q & ~ext_reset_pin_n;
  // standby option keeps dividers running in halt
  assign run_div = (state_q != ST_HALT) | standby_option; // RULE_14 RULE_08
  assign clr_wdt = wdt_option_on & (cmd_q[`ITWHC_CMD_CLRWDT] | cmd_q[`ITWHC_CMD_HALT]); // RULE_07 RULE_10
  assign wdt_overflow = wdt_evt & wdt_option_on; // RULE_07
  assign set_cf = counter_overflow;
  assign set_tf = tick_evt; // RULE_13
  // sampled only at phase-two pulse
  assign c_req = cf_q & cie_q & gie_q & ~stack_full; // RULE_23 RULE_24
  assign t_req = tf_q & tie_q & gie_q & ~stack_full; // RULE_02 RULE_24

  itwhc_divider u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run_div),
    .clear_all(chip_reset),
    .clear_wdt(clr_wdt | pin_fall),
    .wdt_on(wdt_option_on),
    .rate(rate_q),
    .tick_evt(tick_evt),
    .wdt_evt(wdt_evt),
    .fs8(fs8)
  );

  // command register write is a one-cycle pulse
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      cmd_q <= 6'h00;
      pin_q <= 1'b1;
    end
    else
    begin
      pin_q <= ext_reset_pin_n;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= acc_ok & hwrite;
      if (acc_ok)
        wr_addr_q <= haddr;
      cmd_q <= 6'h00;
      if (wr_pend_q && wr_addr_q == `ITWHC_OFS_CMD)
        cmd_q <= hwdata[5:0];
      if (acc_ok && !hwrite)
      begin
        case (haddr)
          `ITWHC_OFS_TICK: hrdata <= {29'h0, rate_q};
          `ITWHC_OFS_STAT: hrdata <= {26'h0, tof_q, pdf_q, 4'h0};
          `ITWHC_OFS_IRQ: hrdata <= {24'h0, irq_word(gie_q, cie_q, tie_q, cf_q, tf_q)};
          `ITWHC_OFS_CPU: hrdata <= {27'h0, state_q, sp_q};
          `ITWHC_OFS_WAKE: hrdata <= {29'h0, osc_128k_option, tf_mask_q, cf_mask_q};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // control state, interrupts, halt and reset cause
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= ST_RUN;
      gie_q <= 1'b0;
      cie_q <= 1'b0;
      tie_q <= 1'b0;
      cf_q <= 1'b0;
      tf_q <= 1'b0;
      rate_q <= `ITWHC_RATE_RST;
      tof_q <= 1'b0;
      pdf_q <= 1'b0;
      sp_q <= 2'h0;
      cf_mask_q <= 1'b0;
      tf_mask_q <= 1'b0;
      wake_cnt_q <= 2'h0;
      clock_phase_one_en <= 1'b1;
      chip_reset <= 1'b0;
      warm_reset <= 1'b0;
      call_req <= 1'b0;
      call_vector <= `ITWHC_VEC_RST;
      resume_next <= 1'b0;
      halted <= 1'b0;
      lcd_clk <= 1'b0;
      osc_run <= 1'b1;
    end
    else
    begin
      chip_reset <= 1'b0;
      warm_reset <= 1'b0;
      call_req <= 1'b0;
      resume_next <= 1'b0;
      lcd_clk <= fs8; // RULE_12
      // oscillator rate is a fixed option; processor clock stays 32k
      osc_run <= (state_q != ST_HALT) | standby_option; // RULE_22 RULE_15
      // software register writes; flags cannot be touched via status
      if (wr_pend_q && wr_addr_q == `ITWHC_OFS_TICK)
        rate_q <= hwdata[2:0]; // RULE_13
      if (wr_pend_q && wr_addr_q == `ITWHC_OFS_IRQ)
      begin
        gie_q <= hwdata[`ITWHC_B_GIE]; // RULE_01 RULE_03
        cie_q <= hwdata[`ITWHC_B_CIE];
        tie_q <= hwdata[`ITWHC_B_TIE];
        cf_q <= hwdata[`ITWHC_B_CF];
        tf_q <= hwdata[`ITWHC_B_TF];
      end
      // hardware sets win over software clears
      if (set_cf)
        cf_q <= 1'b1;
      if (set_tf)
        tf_q <= 1'b1;
      if (cmd_q[`ITWHC_CMD_CALL] && sp_q != 2'h2)
        sp_q <= sp_q + 2'h1;
      if ((cmd_q[`ITWHC_CMD_RET] || cmd_q[`ITWHC_CMD_IRQ_RETURN_INSTR]) && sp_q != 2'h0)
        sp_q <= sp_q - 2'h1;
      if (cmd_q[`ITWHC_CMD_IRQ_RETURN_INSTR])
        gie_q <= 1'b1; // RULE_04 RULE_03 RULE_26
      if (cmd_q[`ITWHC_CMD_CLRWDT] && wdt_option_on)
      begin
        tof_q <= 1'b0; // RULE_25
        pdf_q <= 1'b0;
      end
      case (state_q)
        ST_RUN:
        begin
          halted <= 1'b0;
          clock_phase_one_en <= 1'b1;
          if (clock_phase_two && (c_req || t_req))
          begin
            call_req <= 1'b1; // RULE_05
            sp_q <= sp_q + 2'h1;
            gie_q <= 1'b0; // RULE_02 RULE_23
            if (c_req)
            begin
              call_vector <= `ITWHC_VEC_CNT; // RULE_06
              cf_q <= set_cf; // RULE_26
            end
            else
            begin
              call_vector <= `ITWHC_VEC_TICK; // RULE_06
              tf_q <= set_tf;
            end
          end
          if (cmd_q[`ITWHC_CMD_HALT])
          begin
            state_q <= ST_HALT; // RULE_15
            clock_phase_one_en <= 1'b0;
            halted <= 1'b1;
            pdf_q <= 1'b1;
            tof_q <= 1'b0;
            cf_mask_q <= cf_q; // RULE_21
            tf_mask_q <= tf_q;
          end
          else if (wdt_overflow)
          begin
            chip_reset <= 1'b1; // RULE_09
            tof_q <= 1'b1; // RULE_18
          end
        end
        ST_HALT:
        begin
          if (wdt_overflow)
          begin
            warm_reset <= 1'b1; // RULE_09 RULE_08
            tof_q <= 1'b1; // RULE_18
            sp_q <= 2'h0;
            state_q <= ST_RUN;
            clock_phase_one_en <= 1'b1;
            halted <= 1'b0;
          end
          else if (port_wake || (set_cf && !cf_mask_q) || (set_tf && !tf_mask_q))
          begin
            if ((set_cf && !cf_mask_q && cie_q && gie_q && !stack_full) ||
                (set_tf && !tf_mask_q && tie_q && gie_q && !stack_full))
            begin
              state_q <= ST_WAKE; // RULE_16 RULE_17
              wake_cnt_q <= `ITWHC_WAKE_DLY;
            end
            else
            begin
              state_q <= ST_RUN; // RULE_16 RULE_17
              resume_next <= 1'b1;
              halted <= 1'b0;
              clock_phase_one_en <= 1'b1;
            end
          end
        end
        ST_WAKE:
        begin
          clock_phase_one_en <= 1'b1;
          halted <= 1'b0;
          if (wake_cnt_q == 2'h0)
            state_q <= ST_RUN; // RULE_17
          else
            wake_cnt_q <= wake_cnt_q - 2'h1;
        end
        default: state_q <= ST_RUN;
      endcase
      if (pin_fall || cmd_q[`ITWHC_CMD_PWRUP] || (state_q == ST_RUN && wdt_overflow && !cmd_q[`ITWHC_CMD_HALT]))
      begin
        chip_reset <= 1'b1; // RULE_19
        call_vector <= `ITWHC_VEC_RST;
        gie_q <= 1'b0; // RULE_20
        cie_q <= 1'b0;
        tie_q <= 1'b0;
        cf_q <= 1'b0;
        tf_q <= 1'b0;
        rate_q <= `ITWHC_RATE_RST;
        sp_q <= 2'h0;
        state_q <= ST_RUN;
        halted <= 1'b0;
        clock_phase_one_en <= 1'b1;
        if (cmd_q[`ITWHC_CMD_PWRUP])
        begin
          tof_q <= 1'b0; // RULE_18
          pdf_q <= 1'b0;
        end
        else if (pin_fall && state_q != ST_RUN)
        begin
          tof_q <= 1'b0; // RULE_18
          pdf_q <= 1'b1;
        end
      end
    end
  end
endmodule

//--- verif/itwhc_top_asserts.sv
/*
 port assertions for itwhc_top.
 assumes bind to itwhc_top; one clock, async active-low reset.
*/
`timescale 1ns/10ps
`include "itwhc_consts.vh"
module itwhc_top_asserts (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins and cpu control
  input wire logic ext_reset_pin_n,
  input wire logic clock_phase_two,
  input wire logic port_wake,
  input wire logic clock_phase_one_en,
  input wire logic chip_reset,
  input wire logic warm_reset,
  input wire logic call_req,
  input wire logic [11:0] call_vector,
  input wire logic resume_next,
  input wire logic halted,
  input wire logic lcd_clk
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  a_read_hold: assert property ($changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite))
    else $error("read data moved without a read");
  a_vec_legal: assert property (call_req |-> call_vector == `ITWHC_VEC_CNT || call_vector == `ITWHC_VEC_TICK)
    else $error("bad call vector");
  a_call_phase: assert property (call_req |-> $past(clock_phase_two))
    else $error("call not after phase two");
  a_halt_phase: assert property (halted |-> !clock_phase_one_en)
    else $error("phase one runs in halt");
  a_warm_halt: assert property (warm_reset |-> $past(halted))
    else $error("warm reset outside halt");
  a_pin_reset: assert property ($fell(ext_reset_pin_n) |-> ##[1:3] chip_reset)
    else $error("reset pin gave no chip reset");
  a_port_wake: assert property (halted && port_wake |-> ##[1:4] resume_next)
    else $error("port wake did not resume");
  a_lcd_rate: assert property (!chip_reset ##1 $rose(lcd_clk) ##0 !chip_reset [*8] |-> ##1 $rose(lcd_clk))
    else $error("display clock not one eighth");
  c_call_cnt: cover property (call_req && call_vector == `ITWHC_VEC_CNT);
  c_call_tick: cover property (call_req && call_vector == `ITWHC_VEC_TICK);
  c_wake: cover property (halted ##[1:4] resume_next);
endmodule
bind itwhc_top itwhc_top_asserts itwhc_top_asserts_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .ext_reset_pin_n(ext_reset_pin_n), .clock_phase_two(clock_phase_two), .port_wake(port_wake),
  .clock_phase_one_en(clock_phase_one_en), .chip_reset(chip_reset), .warm_reset(warm_reset),
  .call_req(call_req), .call_vector(call_vector), .resume_next(resume_next), .halted(halted), .lcd_clk(lcd_clk));

//--- verif/itwhc_top_bench.sv
/*
 self-checking bench for itwhc_top.
 assumes zero-wait ahb-lite slave and one-cycle command pulses.
*/
`timescale 1ns/10ps
`include "itwhc_consts.vh"
module itwhc_top_bench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, hrdata, rd, w;
  logic osc_opt = 0, ext_n = 1, ph2 = 0, port_wake = 0, c_ovf = 0, wdt_opt = 1;
  logic p1, crst, wrst, call_req, resume_next, halted, lcd_clk, osc_run;
  logic [11:0] call_vector, vec;
  int errors = 0, checked = 0, cyc = 0, t1;

  always #12.5 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    ph2 <= (cyc % 4 == 3);
  end

  itwhc_top itwhc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .hready(hreadyout), .wdt_option_on(wdt_opt), .osc_128k_option(osc_opt), .standby_option(1'h1),
    .ext_reset_pin_n(ext_n), .clock_phase_two(ph2), .port_wake(port_wake), .counter_overflow(c_ovf),
    .clock_phase_one_en(p1), .chip_reset(crst), .warm_reset(wrst), .call_req(call_req),
    .call_vector(call_vector), .resume_next(resume_next), .halted(halted), .lcd_clk(lcd_clk), .osc_run(osc_run));

  task end_sim;
  begin
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
  begin
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  end
  endtask

  // master holds each phase until hready is sampled high
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
  begin
    hsel <= 1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
    // an address phase that never completes is a timeout as well
    if (n >= 20)
      n = 40;
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    if (n >= 40)
    begin
      errors++;
      end_sim;
    end
  end
  endtask

  // readable bits of the irq control word except global enable (bit 0)
  function automatic logic [31:0] irq_exp(input logic [31:0] v);
    return v & 32'h36;
  endfunction

  task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
  begin
    bus(1'b0, a, 32'h0);
    check("register", rd & m, e);
  end
  endtask

  task cmd(input int b);
  begin
    bus(1'b1, `ITWHC_OFS_CMD, 32'h1 << b);
  end
  endtask

  // 0 call, 1 resume, 2 halted, 3 chip reset
  task wait_out(input int which);
    int n;
    logic hit;
  begin
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
      hit = which == 0 ? call_req : which == 1 ? resume_next : which == 2 ? halted : crst;
    end while (hit !== 1'b1 && n < 3000);
    vec = call_vector;
    if (n >= 3000)
    begin
      errors++;
      end_sim;
    end
  end
  endtask

  task no_call(input int n);
  begin
    repeat (n)
    begin
      @(posedge hclk);
      check("no call", call_req, 0);
    end
  end
  endtask

  initial
  begin
    rd = $urandom(32'h4021);
    osc_opt <= $urandom % 2;
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    rd_chk(`ITWHC_OFS_TICK, 32'h7, 32'h7);
    rd_chk(`ITWHC_OFS_IRQ, 32'hFF, 32'h0);
    rd_chk(`ITWHC_OFS_STAT, 32'h30, 32'h0);
    rd_chk(`ITWHC_OFS_WAKE, 32'h4, {29'h0, osc_opt, 2'h0});
    rd_chk(8'h40, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, `ITWHC_OFS_STAT, 32'hFF);
    rd_chk(`ITWHC_OFS_STAT, 32'h30, 32'h0);
    repeat (4)
    begin
      w = $urandom & 32'hFE;
      bus(1'b1, `ITWHC_OFS_IRQ, w);
      rd_chk(`ITWHC_OFS_IRQ, 32'hFF, irq_exp(w));
    end
    // hardware flag, then both pending
    bus(1'b1, `ITWHC_OFS_IRQ, 32'h06);
    c_ovf <= 1;
    @(posedge hclk);
    c_ovf <= 0;
    rd_chk(`ITWHC_OFS_IRQ, 32'hFF, 32'h16);
    bus(1'b1, `ITWHC_OFS_IRQ, 32'h37);
    wait_out(0);
    check("vector", vec, `ITWHC_VEC_CNT);
    rd_chk(`ITWHC_OFS_IRQ, 32'hFF, 32'h26);
    no_call(12);
    cmd(`ITWHC_CMD_IRQ_RETURN_INSTR);
    wait_out(0);
    check("vector", vec, `ITWHC_VEC_TICK);
    rd_chk(`ITWHC_OFS_IRQ, 32'hFF, 32'h06);
    cmd(`ITWHC_CMD_RET);
    rd_chk(`ITWHC_OFS_IRQ, 32'hFF, 32'h06);
    // stack full holds off the tick
    cmd(`ITWHC_CMD_CALL);
    cmd(`ITWHC_CMD_CALL);
    bus(1'b1, `ITWHC_OFS_IRQ, 32'h25);
    no_call(16);
    cmd(`ITWHC_CMD_RET);
    wait_out(0);
    check("vector", vec, `ITWHC_VEC_TICK);
    cmd(`ITWHC_CMD_RET);
    cmd(`ITWHC_CMD_RET);
    // first interval after a rate change may be short
    for (int r = 0; r < 3; r++)
    begin
      bus(1'b1, `ITWHC_OFS_IRQ, 32'h0);
      bus(1'b1, `ITWHC_OFS_TICK, r);
      bus(1'b1, `ITWHC_OFS_IRQ, 32'h05);
      wait_out(0);
      cmd(`ITWHC_CMD_IRQ_RETURN_INSTR);
      wait_out(0);
      t1 = cyc;
      cmd(`ITWHC_CMD_IRQ_RETURN_INSTR);
      wait_out(0);
      check("tick period", cyc - t1, 32'd256 << r);
      cmd(`ITWHC_CMD_RET);
    end
    bus(1'b1, `ITWHC_OFS_IRQ, 32'h0);
    cmd(`ITWHC_CMD_HALT);
    wait_out(2);
    check("phase one", p1, 0);
    check("osc run", osc_run, 1);
    port_wake <= 1;
    @(posedge hclk);
    port_wake <= 0;
    wait_out(1);
    rd_chk(`ITWHC_OFS_STAT, 32'h30, 32'h10);
    bus(1'b1, `ITWHC_OFS_TICK, 32'h2);
    ext_n <= 0;
    wait_out(3);
    ext_n <= 1;
    repeat (4) @(posedge hclk);
    rd_chk(`ITWHC_OFS_STAT, 32'h30, 32'h10);
    rd_chk(`ITWHC_OFS_TICK, 32'h7, 32'h7);
    rd_chk(`ITWHC_OFS_IRQ, 32'hFF, 32'h0);
    cmd(`ITWHC_CMD_PWRUP);
    @(posedge hclk);
    rd_chk(`ITWHC_OFS_STAT, 32'h30, 32'h0);
    // tick flag set before halt masks its wake: only the watchdog ends this halt
    bus(1'b1, `ITWHC_OFS_IRQ, 32'h20);
    cmd(`ITWHC_CMD_CALL);
    cmd(`ITWHC_CMD_HALT);
    t1 = 0;
    while (wrst !== 1'b1 && t1 < 70000)
    begin
      @(posedge hclk);
      t1++;
    end
    check("warm reset", wrst, 1);
    if (t1 >= 70000)
      end_sim;
    rd_chk(`ITWHC_OFS_STAT, 32'h30, 32'h30);
    rd_chk(`ITWHC_OFS_IRQ, 32'hFF, 32'h20);
    rd_chk(`ITWHC_OFS_CPU, 32'h1F, 32'h04);
    // watchdog removed: its clear must not touch the flags
    wdt_opt <= 0;
    cmd(`ITWHC_CMD_CLRWDT);
    @(posedge hclk);
    rd_chk(`ITWHC_OFS_STAT, 32'h30, 32'h30);
    wdt_opt <= 1;
    cmd(`ITWHC_CMD_CLRWDT);
    @(posedge hclk);
    rd_chk(`ITWHC_OFS_STAT, 32'h30, 32'h0);
    end_sim;
  end
endmodule
